// ==== verilog/sccc_capcom.v ====
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "sccc_defines.vh"

// Notes on behaviour
// - Sixteen channels; one-cycle resolution, or eight cycles when staggered.
// - Two independent 16-bit time bases, each with a reload register.
// - Time base clocked by prescaled system clock or external timer overflow.
// - First time base may count rising edges of an external count input.
// - Each channel picks its time base and capture or compare function.
// - One pin per channel: capture input or compare output.
// - Capture copies the chosen time base into the channel register.
// - Every capture raises that channel's interrupt request.
// - Capture trigger: rising, falling or both edges, per channel.
// - Compare channels match against their time base and act by mode.
// - Mode 0: interrupt only, several per period.
// - Mode 1: pin toggles on every match, several per period.
// - Mode 2: interrupt only, at most one per period.
// - Mode 3: pin high on match, low on overflow, once per period.
// - Double mode: two channels toggle one shared pin on either match.
// - Single-event option allows one capture or match in any mode, so one edge or pulse in modes 1 and 3.

module sccc_capcom (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire [15:0] pinIn,
  output reg  [15:0] pinOut,
  output reg  [15:0] pinOe,
  input  wire        extCount,
  input  wire        extOverflow,
  output reg         irq
);

  // ==========================================================
  // Registers and wires
  reg  [8:0]   ctrl;
  reg  [15:0]  cntA;
  reg  [15:0]  relA;
  reg  [15:0]  cntB;
  reg  [15:0]  relB;
  reg          updA;
  reg          updB;
  reg          ovA;
  reg          ovB;
  reg  [2:0]   presc;
  reg  [2:0]   stag;
  reg  [15:0]  sts;
  reg  [15:0]  msk;
  reg  [7:0]   dbl;
  reg  [6:0]   cfg [0:15];
  reg  [16:0]  syn1;
  reg  [16:0]  syn2;
  reg  [16:0]  syn3;
  reg  [16:0]  lvl;
  reg  [16:0]  lvlQ;
  reg          wrPend;
  reg  [7:0]   wrAddr;
  reg  [31:0]  next_hrdata;
  reg  [15:0]  next_pinOut;
  reg  [15:0]  next_pinOe;
  reg  [15:0]  cfgWr;
  reg  [15:0]  valWr;
  wire [255:0] vals;
  wire [15:0]  evt;
  wire [15:0]  tgl;
  wire [15:0]  setP;
  wire [15:0]  clrP;
  wire [16:0]  rise = lvl & ~lvlQ;
  wire [16:0]  fall = ~lvl & lvlQ;
  wire         addrPhase = hsel & htrans[1] & hready;
  wire         tickA;
  wire         tickB;
  integer      i;
  integer      j;

  // ==========================================================
  // Functions
  function srcTick;
    input [2:0] src;
    input [2:0] pc;
    input       ovf;
    input       ext;
    begin
      case (src)
        `SCCC_SRC_DIV1: srcTick = 1'b1;
        `SCCC_SRC_DIV2: srcTick = pc[0];
        `SCCC_SRC_DIV4: srcTick = &pc[1:0];
        `SCCC_SRC_DIV8: srcTick = &pc;
        `SCCC_SRC_OVF:  srcTick = ovf;
        `SCCC_SRC_EXT:  srcTick = ext;
        default:        srcTick = 1'b0;
      endcase
    end
  endfunction

  function [15:0] nextCount;
    input [15:0] cnt;
    input [15:0] rel;
    begin
      if (cnt == `SCCC_TOP)
        nextCount = rel;
      else
        nextCount = cnt + 16'h0001;
    end
  endfunction

  function isDriver;
    input [6:0] c;
    begin
      isDriver = c[2] & c[0];
    end
  endfunction

  // ==========================================================
  // Time base clocking
  // Staggered operation lets a base move at most every eighth cycle
  wire stagOk = ~ctrl[`SCCC_CTRL_STAG] | (&stag);

  assign tickA = ctrl[`SCCC_CTRL_RUNA] & stagOk
               & srcTick(ctrl[`SCCC_CTRL_CLKA], presc, extOverflow, rise[16]);
  // The external count input belongs to the first base only
  assign tickB = ctrl[`SCCC_CTRL_RUNB] & stagOk
               & srcTick(ctrl[`SCCC_CTRL_CLKB], presc, extOverflow, 1'b0);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc <= 3'h0;
      stag  <= 3'h0;
      cntA  <= 16'h0000;
      cntB  <= 16'h0000;
      updA  <= 1'b0;
      updB  <= 1'b0;
      ovA   <= 1'b0;
      ovB   <= 1'b0;
    end else begin
      presc <= presc + 3'h1;
      stag  <= stag + 3'h1;
      // A software write to a count wins over a tick in the same cycle
      if (wrPend && wrAddr == `SCCC_OFF_CNTA)
        cntA <= hwdata[15:0];
      else if (tickA)
        cntA <= nextCount(cntA, relA);
      if (wrPend && wrAddr == `SCCC_OFF_CNTB)
        cntB <= hwdata[15:0];
      else if (tickB)
        cntB <= nextCount(cntB, relB);
      updA <= tickA;
      updB <= tickB;
      ovA  <= tickA & (cntA == `SCCC_TOP);
      ovB  <= tickB & (cntB == `SCCC_TOP);
    end
  end

  // ==========================================================
  // Pin and count input synchronisers
  // A level is accepted once the second and third stages agree
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syn1 <= 17'h00000;
      syn2 <= 17'h00000;
      syn3 <= 17'h00000;
      lvl  <= 17'h00000;
      lvlQ <= 17'h00000;
    end else begin
      syn1 <= {extCount, pinIn};
      syn2 <= syn1;
      syn3 <= syn2;
      lvl  <= (syn3 & ~(syn2 ^ syn3)) | (lvl & (syn2 ^ syn3));
      lvlQ <= lvl;
    end
  end

  // ==========================================================
  // Bus slave: address phase captured, write done in data phase
  always @* begin
    cfgWr = 16'h0000;
    valWr = 16'h0000;
    if (wrPend && wrAddr[7:6] == `SCCC_CFG_PAGE)
      cfgWr[wrAddr[5:2]] = 1'b1;
    if (wrPend && wrAddr[7:6] == `SCCC_VAL_PAGE)
      valWr[wrAddr[5:2]] = 1'b1;
  end

  always @* begin
    next_hrdata = 32'h00000000;
    case (haddr[7:0])
      `SCCC_OFF_CTRL: next_hrdata[8:0]  = ctrl;
      `SCCC_OFF_CNTA: next_hrdata[15:0] = cntA;
      `SCCC_OFF_RELA: next_hrdata[15:0] = relA;
      `SCCC_OFF_CNTB: next_hrdata[15:0] = cntB;
      `SCCC_OFF_RELB: next_hrdata[15:0] = relB;
      `SCCC_OFF_STS:  next_hrdata[15:0] = sts;
      `SCCC_OFF_MSK:  next_hrdata[15:0] = msk;
      `SCCC_OFF_DBL:  next_hrdata[7:0]  = dbl;
      `SCCC_OFF_PIN:  next_hrdata = {pinOut, lvl[15:0]};
      default: begin
        if (haddr[7:6] == `SCCC_CFG_PAGE)
          next_hrdata[6:0] = cfg[haddr[5:2]];
        else if (haddr[7:6] == `SCCC_VAL_PAGE)
          next_hrdata[15:0] = vals[haddr[5:2]*16 +: 16];
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend    <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr <= haddr[7:0];
        if (!hwrite)
          hrdata <= next_hrdata;
      end
    end
  end

  // ==========================================================
  // Software registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= 9'h000;
      relA <= 16'h0000;
      relB <= 16'h0000;
      msk  <= 16'h0000;
      dbl  <= 8'h00;
      for (i = 0; i < `SCCC_NCH; i = i + 1) begin
        cfg[i] <= 7'h00;
      end
    end else begin
      if (wrPend) begin
        case (wrAddr)
          `SCCC_OFF_CTRL: ctrl <= hwdata[8:0];
          `SCCC_OFF_RELA: relA <= hwdata[15:0];
          `SCCC_OFF_RELB: relB <= hwdata[15:0];
          `SCCC_OFF_MSK:  msk  <= hwdata[15:0];
          `SCCC_OFF_DBL:  dbl  <= hwdata[7:0];
          default: begin
            if (wrAddr[7:6] == `SCCC_CFG_PAGE)
              cfg[wrAddr[5:2]] <= hwdata[6:0];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Interrupt status: a new event beats a write-one-to-clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sts <= 16'h0000;
      irq <= 1'b0;
    end else begin
      if (wrPend && wrAddr == `SCCC_OFF_STS)
        sts <= (sts & ~hwdata[15:0]) | evt;
      else
        sts <= sts | evt;
      irq <= |(sts & msk);
    end
  end

  // ==========================================================
  // Channel array
  genvar g;
  generate
    for (g = 0; g < `SCCC_NCH; g = g + 1) begin : gCh
      sccc_channel uCh (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cfg     (cfg[g]),
        .cfgWr   (cfgWr[g]),
        .valWr   (valWr[g]),
        .wdata   (hwdata[15:0]),
        .timeA   (cntA),
        .timeB   (cntB),
        .updA    (updA),
        .updB    (updB),
        .ovA     (ovA),
        .ovB     (ovB),
        .rise    (rise[g]),
        .fall    (fall[g]),
        .value   (vals[g*16 +: 16]),
        .evt     (evt[g]),
        .tgl     (tgl[g]),
        .setP    (setP[g]),
        .clrP    (clrP[g])
      );
    end
  endgenerate

  // ==========================================================
  // Pin drivers
  // In double mode the upper partner gives up its own pin
  always @* begin
    next_pinOut = pinOut;
    next_pinOe  = 16'h0000;
    for (j = 0; j < `SCCC_NCH; j = j + 1) begin
      next_pinOe[j] = isDriver(cfg[j]);
      if (tgl[j])
        next_pinOut[j] = ~next_pinOut[j];
      if (setP[j])
        next_pinOut[j] = 1'b1;
      if (clrP[j])
        next_pinOut[j] = 1'b0;
    end
    for (j = 0; j < `SCCC_NCH / 2; j = j + 1) begin
      if (dbl[j]) begin
        next_pinOe[j + 8] = 1'b0;
        next_pinOe[j]     = isDriver(cfg[j]) | isDriver(cfg[j + 8]);
        if (tgl[j + 8])
          next_pinOut[j] = ~next_pinOut[j];
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut <= 16'h0000;
      pinOe  <= 16'h0000;
    end else begin
      pinOut <= next_pinOut;
      pinOe  <= next_pinOe;
    end
  end

endmodule

// ==== inc/sccc_defines.vh ====
`ifndef SCCC_DEFINES_VH
`define SCCC_DEFINES_VH

// ==========================================================
// Register byte offsets (low address byte)
`define SCCC_OFF_CTRL   8'h00
`define SCCC_OFF_CNTA   8'h04
`define SCCC_OFF_RELA   8'h08
`define SCCC_OFF_CNTB   8'h0C
`define SCCC_OFF_RELB   8'h10
`define SCCC_OFF_STS    8'h14
`define SCCC_OFF_MSK    8'h18
`define SCCC_OFF_DBL    8'h1C
`define SCCC_OFF_PIN    8'h20
`define SCCC_CFG_PAGE   2'h1
`define SCCC_VAL_PAGE   2'h2

// ==========================================================
// Control register fields
`define SCCC_CTRL_RUNA  0
`define SCCC_CTRL_CLKA  3:1
`define SCCC_CTRL_RUNB  4
`define SCCC_CTRL_CLKB  7:5
`define SCCC_CTRL_STAG  8
`define SCCC_CTRL_W     9

// ==========================================================
// Channel configuration fields
`define SCCC_CFG_MODE   2:0
`define SCCC_CFG_EDGE   4:3
`define SCCC_CFG_RISE   3
`define SCCC_CFG_FALL   4
`define SCCC_CFG_TSEL   5
`define SCCC_CFG_SE     6
`define SCCC_CFG_W      7

// ==========================================================
// Channel modes and compare sub-modes
`define SCCC_MODE_OFF   3'h0
`define SCCC_MODE_CAP   3'h1
`define SCCC_CMP_TGL    2'h1
`define SCCC_CMP_ONCE   1
`define SCCC_CMP_SET    2'h3

// ==========================================================
// Time base clock sources
`define SCCC_SRC_DIV1   3'h0
`define SCCC_SRC_DIV2   3'h1
`define SCCC_SRC_DIV4   3'h2
`define SCCC_SRC_DIV8   3'h3
`define SCCC_SRC_OVF    3'h4
`define SCCC_SRC_EXT    3'h5

`define SCCC_TOP        16'hFFFF
`define SCCC_NCH        16

`endif

// ==== verilog/sccc_channel.v ====
`timescale 1ns/100ps
`include "sccc_defines.vh"

module sccc_channel (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [6:0]  cfg,
  input  wire        cfgWr,
  input  wire        valWr,
  input  wire [15:0] wdata,
  input  wire [15:0] timeA,
  input  wire [15:0] timeB,
  input  wire        updA,
  input  wire        updB,
  input  wire        ovA,
  input  wire        ovB,
  input  wire        rise,
  input  wire        fall,
  output reg  [15:0] value,
  output reg         evt,
  output reg         tgl,
  output reg         setP,
  output reg         clrP
);

  wire        useB  = cfg[`SCCC_CFG_TSEL];
  wire [15:0] tNow  = useB ? timeB : timeA;
  wire        upd   = useB ? updB : updA;
  wire        ov    = useB ? ovB : ovA;
  wire [2:0]  mode  = cfg[`SCCC_CFG_MODE];
  wire [1:0]  cm    = mode[1:0];
  wire        isCmp = mode[2];
  reg         once;
  reg         done;

  // Match is judged only on the cycle after the time base moved
  // The overflow cycle already belongs to the new period, so once is disregarded there
  wire hit   = isCmp & upd & (tNow == value) & ~done
             & ~(cm[`SCCC_CMP_ONCE] & once & ~ov);
  wire capEv = (mode == `SCCC_MODE_CAP) & ~done
             & ((rise & cfg[`SCCC_CFG_RISE]) | (fall & cfg[`SCCC_CFG_FALL]));

  // ==========================================================
  // Channel state
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value <= 16'h0000;
      evt   <= 1'b0;
      tgl   <= 1'b0;
      setP  <= 1'b0;
      clrP  <= 1'b0;
      once  <= 1'b0;
      done  <= 1'b0;
    end else begin
      if (valWr)
        value <= wdata;
      else if (capEv)
        value <= tNow;
      evt  <= capEv | hit;
      tgl  <= hit & (cm == `SCCC_CMP_TGL);
      setP <= hit & (cm == `SCCC_CMP_SET);
      clrP <= isCmp & (cm == `SCCC_CMP_SET) & ov;
      // A match on the reloaded value opens the new period at once
      once <= hit | (once & ~ov);
      // Single event: stays silent until software rewrites the config
      if (cfgWr)
        done <= 1'b0;
      else if (cfg[`SCCC_CFG_SE] & (hit | capEv))
        done <= 1'b1;
    end
  end

endmodule

// ==== dv/sccc_capcom_asserts.sv ====
`timescale 1ns/100ps
// ========
// Port-level checker
module sccc_capcom_asserts (
  input wire        clk,
  input wire        sys_rst,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire [31:0] hrdata,
  input wire        hresp,
  input wire [15:0] pinOut,
  input wire [15:0] pinOe,
  input wire        irq
);
  reg        dWr;
  reg [7:0]  dAddr;
  reg [15:0] maskSh;
  wire       taken = hsel & htrans[1] & hready;
  wire       rdTaken = taken & ~hwrite;

  // Shadow of the mask so irq can be judged from the bus alone
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dWr    <= 1'h0;
      dAddr  <= 8'h00;
      maskSh <= 16'h0000;
    end else begin
      if (dWr && dAddr == 8'h18)
        maskSh <= hwdata[15:0];
      dWr   <= taken & hwrite;
      dAddr <= haddr[7:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_READY: assert property (hreadyout)
    else $error("zero wait state broken");
  AST_RESP: assert property (!hresp)
    else $error("non-OKAY response");
  AST_RST: assert property (disable iff (1'h0) sys_rst |-> !irq && pinOut == 16'h0000 && pinOe == 16'h0000)
    else $error("outputs active in reset");
  AST_HOLD: assert property (!rdTaken |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (rdTaken && haddr[7:0] inside {[8'h24:8'h3C]} |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER: assert property (rdTaken && haddr[7:0] != 8'h20 |=> hrdata[31:16] == 16'h0000)
    else $error("upper half of a 16-bit register not zero");
  AST_PINRD: assert property (rdTaken && haddr[7:0] == 8'h20 |=> hrdata[31:16] == $past(pinOut))
    else $error("pin readback differs from pin outputs");
  AST_IRQ_MASK: assert property (maskSh == 16'h0000 && $past(maskSh) == 16'h0000 |-> !irq)
    else $error("irq with all sources masked");

  COV_IRQ: cover property ($rose(irq));
  COV_PIN: cover property (pinOut != $past(pinOut));
  COV_PINRD: cover property (rdTaken && haddr[7:0] == 8'h20);
endmodule

bind sccc_capcom sccc_capcom_asserts u_chk (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .pinOut(pinOut), .pinOe(pinOe), .irq(irq)
);

// ==== dv/sccc_pin_model.sv ====
`timescale 1ns/100ps
// ========
// Pins, external count source and overflow timer
module sccc_pin_model #(
  parameter OVF_PERIOD = 10,
  parameter CNT_HALF   = 4
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        runExt,
  input  wire [15:0] pinCmd,
  input  wire [15:0] pinOut,
  input  wire [15:0] pinOe,
  output reg  [15:0] pinIn,
  output reg         extOverflow,
  output reg         extCount
);
  integer div;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div         <= 0;
      extOverflow <= 1'h0;
      extCount    <= 1'h0;
      pinIn       <= 16'h0000;
    end else begin
      // A driven pin shows the block's level, otherwise the outside level
      pinIn       <= (pinOe & pinOut) | (~pinOe & pinCmd);
      div         <= runExt ? div + 1 : 0;
      extOverflow <= runExt && (div % OVF_PERIOD == OVF_PERIOD - 1);
      if (runExt && (div % CNT_HALF == CNT_HALF - 1))
        extCount <= ~extCount;
    end
  end
endmodule

// ==== dv/sccc_tb.sv ====
`timescale 1ns/100ps
// ========
// Bench top
module testbench;
  reg         clk;
  reg         sys_rst;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg  [15:0] pinCmd;
  reg         runExt;
  reg  [15:0] prevOut;
  reg  [31:0] rd;
  wire        hreadyout;
  wire        hresp;
  wire [31:0] hrdata;
  wire [15:0] pinIn;
  wire [15:0] pinOut;
  wire [15:0] pinOe;
  wire        extCount;
  wire        extOverflow;
  wire        irq;
  integer     mismatches;
  integer     n_compared;
  integer     i;
  integer     k;
  integer     chg [0:15];
  // Channels 0..5: cmp1, cmp2, cmp0, cmp3, cmp1 single, cmp1 paired with 13
  localparam [47:0] CFGS = 48'h054507040605;
  // Channel 13 still toggles its own undriven output level on its two matches
  localparam [63:0] EXP_CHG = 64'h0020000000415003;

  sccc_capcom u_dut (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .extCount(extCount),
    .extOverflow(extOverflow), .irq(irq)
  );

  sccc_pin_model u_pins (
    .clk(clk), .sys_rst(sys_rst), .runExt(runExt), .pinCmd(pinCmd),
    .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn),
    .extOverflow(extOverflow), .extCount(extCount)
  );

  // ========
  // Tasks
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // One idle edge first so a read never overlaps a write data phase
  task busOp(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      do @(posedge clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
      rd = hrdata;
    end
  endtask

  task rdChk(input [7:0] a, input [31:0] exp);
    begin
      busOp(1'h0, a, 32'h0);
      chk(rd, exp);
    end
  endtask

  task tally_and_finish;
    begin
      if (mismatches == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // ========
  // Clock and watchdog
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    tally_and_finish;
  end

  // ========
  // Tests
  initial begin
    sys_rst    = 1'h1;
    hsel       = 1'h0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'h0;
    hwdata     = 32'h0;
    pinCmd     = 16'h0000;
    runExt     = 1'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    rdChk(8'h00, 32'h0);
    rdChk(8'h14, 32'h0);
    busOp(1'h1, 8'h24, 32'hFFFF);
    rdChk(8'h24, 32'h0);
    busOp(1'h1, 8'h08, 32'h1234);
    busOp(1'h1, 8'h04, 32'hFFFE);
    busOp(1'h1, 8'h00, 32'h1);
    repeat (40) @(posedge clk);
    busOp(1'h1, 8'h00, 32'h0);
    busOp(1'h0, 8'h04, 32'h0);
    chk(rd >= 32'h1254 && rd <= 32'h1262, 32'h1);
    busOp(1'h1, 8'h04, 32'h0);
    busOp(1'h1, 8'h00, 32'h101);
    repeat (80) @(posedge clk);
    busOp(1'h1, 8'h00, 32'h0);
    busOp(1'h0, 8'h04, 32'h0);
    chk(rd >= 32'h9 && rd <= 32'hC, 32'h1);
    busOp(1'h1, 8'h04, 32'h0);
    busOp(1'h1, 8'h00, 32'h9B);
    runExt <= 1'h1;
    repeat (100) @(posedge clk);
    busOp(1'h1, 8'h00, 32'h0);
    runExt <= 1'h0;
    busOp(1'h0, 8'h0C, 32'h0);
    chk(rd >= 32'h9 && rd <= 32'hB, 32'h1);
    busOp(1'h0, 8'h04, 32'h0);
    chk(rd >= 32'hB && rd <= 32'hE, 32'h1);
    busOp(1'h1, 8'h08, 32'hFF00);
    busOp(1'h1, 8'h04, 32'hFF00);
    for (k = 0; k < 6; k = k + 1) begin
      busOp(1'h1, 8'h40 + 4 * k, {24'h0, CFGS[8 * k +: 8]});
      busOp(1'h1, 8'h80 + 4 * k, 32'hFF10 + 16 * k);
    end
    busOp(1'h1, 8'h74, 32'h05);
    busOp(1'h1, 8'hB4, 32'hFFC0);
    busOp(1'h1, 8'h1C, 32'h20);
    for (k = 0; k < 16; k = k + 1)
      chg[k] = 0;
    busOp(1'h1, 8'h00, 32'h1);
    prevOut = pinOut;
    for (i = 0; i < 600; i = i + 1) begin
      @(posedge clk);
      #1;
      for (k = 0; k < 16; k = k + 1)
        chg[k] = chg[k] + (pinOut[k] != prevOut[k]);
      prevOut = pinOut;
      if (i == 200)
        chk(pinOut[3], 32'h1);
      if (i == 300)
        chk(pinOut[3], 32'h0);
    end
    for (k = 0; k < 16; k = k + 1)
      chk(chg[k], EXP_CHG[4 * k +: 4]);
    chk(pinOe, 32'h39);
    busOp(1'h1, 8'h00, 32'h0);
    rdChk(8'h14, 32'h203F);
    busOp(1'h1, 8'h18, 32'h2);
    repeat (3) @(posedge clk);
    chk(irq, 32'h1);
    busOp(1'h1, 8'h14, 32'h2);
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
    rdChk(8'h14, 32'h203D);
    busOp(1'h1, 8'h14, 32'hFFFF);
    busOp(1'h1, 8'h04, 32'h123);
    busOp(1'h1, 8'h0C, 32'hABC);
    busOp(1'h1, 8'h60, 32'h09);
    busOp(1'h1, 8'h64, 32'h11);
    busOp(1'h1, 8'h68, 32'h39);
    pinCmd <= 16'h0700;
    repeat (8) @(posedge clk);
    busOp(1'h0, 8'h20, 32'h0);
    chk(rd[15:0], 32'h0719);
    busOp(1'h1, 8'h04, 32'h456);
    busOp(1'h1, 8'h0C, 32'hDEF);
    pinCmd <= 16'h0000;
    repeat (8) @(posedge clk);
    rdChk(8'hA0, 32'h123);
    rdChk(8'hA4, 32'h456);
    rdChk(8'hA8, 32'hDEF);
    rdChk(8'h14, 32'h0700);
    tally_and_finish;
  end
endmodule
